// File: hw/energy_pkg.sv
// Package with offsets, field layout and carrier types for the phase energy accumulators.
// Function
// [R1] Each DSP cycle a positive real power result of a phase is added to its positive real energy.
// [R2] Each DSP cycle a negative real power result adds its magnitude to the negative real energy.
// [R3] Each DSP cycle a positive quadrature power result is added to the positive reactive energy.
// [R4] Each DSP cycle a negative quadrature power result adds its magnitude to the negative reactive energy.
// [R5] Each DSP cycle the volt-amp product of a phase is added to its apparent energy without a sign test.
// [R6] A wrap of the positive real energy sets the positive-real wrap flag of that phase.
// [R7] A wrap of the negative real energy sets the negative-real wrap flag of that phase.
// [R8] A wrap of the positive reactive energy sets the positive-reactive wrap flag of that phase.
// [R9] A wrap of the negative reactive energy sets the negative-reactive wrap flag of that phase.
// [R10] A wrap of the apparent energy sets the apparent wrap flag of that phase.
// [R11] Each of phases A, B and C has its own 32-bit apparent energy register at its own address.
// [R12] Wrap flags stay set until the host clears them by a write; the block never clears them itself.
// [R13] After seeing a wrap flag the host adds two to the thirty-second to the difference of two readings.
// [R14] Every accumulator wraps modulo two to the thirty-second and keeps the low 32 bits of the sum.
package energy_pkg;

   localparam int ACC_W   = 32;
   localparam int POWER_W = 32;
   localparam int PHASES  = 3;
   localparam int KINDS   = 5;
   localparam int ADDR_W  = 12;
   localparam int WRAP_W  = 8;

   // Lane index equals the bit position of its wrap flag.
   localparam int KIND_REAL_POS = 0;
   localparam int KIND_REAL_NEG = 1;
   localparam int KIND_QUAD_POS = 2;
   localparam int KIND_QUAD_NEG = 3;
   localparam int KIND_VA       = 4;

   localparam logic [ACC_W-1:0]  ACC_RESET  = 32'h0000_0000;
   localparam logic [KINDS-1:0]  WRAP_RESET = 5'h00;
   localparam logic [ACC_W-1:0]  READ_ZERO  = 32'h0000_0000;

   // Offsets, phase C first so that index [phase][kind] follows the packed order.
   localparam logic [PHASES-1:0][KINDS-1:0][ADDR_W-1:0] ENERGY_OFS = {
      12'h3D0, 12'h3CC, 12'h3C8, 12'h3C4, 12'h3C0,
      12'h2E4, 12'h2E0, 12'h2DC, 12'h2D8, 12'h2D4,
      12'h1F8, 12'h1F4, 12'h1F0, 12'h1EC, 12'h1E8
   };
   localparam logic [PHASES-1:0][ADDR_W-1:0] WRAP_OFS = {12'h31E, 12'h232, 12'h146};

   typedef logic [KINDS-1:0] wrap_flags_t;

   typedef struct packed {
      logic [POWER_W-1:0] real_power_value;
      logic [POWER_W-1:0] quadrature_power_value;
      logic [POWER_W-1:0] volt_amp_product;
   } phase_power_t;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [WRAP_W-1:0] wdata;
   } reg_req_t;

endpackage : energy_pkg

// File: hw/energy_lane.sv
// One energy accumulator with modulo wrap and a wrap pulse.
`timescale 1ns/1ns
module energy_lane #(
   parameter int ACC_W = energy_pkg::ACC_W
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             add_en,
   input  wire logic [ACC_W-1:0] addend,
   output logic      [ACC_W-1:0] acc,
   output logic                  wrap
);

   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_nxt;
   logic [ACC_W:0]   sum_w;

   if (ACC_W < energy_pkg::POWER_W) begin : g_bad_width
      $error("energy_lane: accumulator narrower than power word");
   end

   // The carry is dropped so the host difference stays exact after a wrap.
   assign sum_w   = {1'b0, acc_r} + {1'b0, addend}; // R14
   assign acc_nxt = add_en ? sum_w[ACC_W-1:0] : acc_r; // R14
   assign wrap    = add_en & sum_w[ACC_W];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= ACC_W'(energy_pkg::ACC_RESET);
      end else begin
         acc_r <= acc_nxt;
      end
   end

   assign acc = acc_r;

endmodule : energy_lane

// File: hw/wrap_status.sv
// Sticky wrap flags of one phase, cleared only by a host write.
`timescale 1ns/1ns
module wrap_status (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire energy_pkg::wrap_flags_t   set_vec,
   input  wire logic                      clr_en,
   input  wire energy_pkg::wrap_flags_t   clr_mask,
   output energy_pkg::wrap_flags_t        flags
);

   energy_pkg::wrap_flags_t flags_r;
   energy_pkg::wrap_flags_t flags_nxt;
   energy_pkg::wrap_flags_t keep_w;

   // A wrap in the cycle of a clear wins, so no event is lost.
   assign keep_w    = clr_en ? (flags_r & ~clr_mask) : flags_r; // R12
   assign flags_nxt = keep_w | set_vec; // R12

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= energy_pkg::WRAP_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags = flags_r;

endmodule : wrap_status

// File: hw/phase_energy_accumulators.sv
// Per-phase energy accumulators with sign split, sticky wrap flags and register read port.
`timescale 1ns/1ns
module phase_energy_accumulators (
   input  wire logic                                            clk_sys,
   input  wire logic                                            rst_n,
   input  wire logic                                            dsp_cycle_strobe,
   input  wire energy_pkg::phase_power_t [energy_pkg::PHASES-1:0] power_in,
   input  wire energy_pkg::reg_req_t                            reg_req,
   output logic [energy_pkg::ACC_W-1:0]                         reg_rdata,
   output logic                                                 reg_rvalid,
   output energy_pkg::wrap_flags_t [energy_pkg::PHASES-1:0]     energy_wrap_status
);

   localparam int ACC_W  = energy_pkg::ACC_W;
   localparam int P_W    = energy_pkg::POWER_W;
   localparam int NP     = energy_pkg::PHASES;
   localparam int NK     = energy_pkg::KINDS;
   localparam int NWORDS = NP * NK + NP;

   // Address match, shared by the read selector and the flag clear decode.
   function automatic logic addr_hit(input logic [energy_pkg::ADDR_W-1:0] addr,
                                     input logic [energy_pkg::ADDR_W-1:0] ofs);
      addr_hit = (addr == ofs);
   endfunction : addr_hit

   // Magnitude of a signed power word; the most negative value maps to 2^31 exactly.
   function automatic logic [P_W-1:0] magnitude(input logic [P_W-1:0] val);
      magnitude = val[P_W-1] ? (~val + P_W'(1)) : val;
   endfunction : magnitude

   function automatic logic [ACC_W-1:0] merge_words(input logic [NWORDS-1:0][ACC_W-1:0] w);
      logic [ACC_W-1:0] m;
      m = energy_pkg::READ_ZERO;
      for (int i = 0; i < NWORDS; i++) begin
         m = m | w[i];
      end
      merge_words = m;
   endfunction : merge_words

   // Power words are captured on the strobe so the adders see a stable set for a whole cycle.
   logic                                        add_r;
   energy_pkg::phase_power_t [NP-1:0]           power_r;
   energy_pkg::phase_power_t [NP-1:0]           power_nxt;
   logic [ACC_W-1:0]                            rdata_r;
   logic [ACC_W-1:0]                            rdata_nxt;
   logic                                        rvalid_r;
   logic [NP-1:0][NK-1:0][ACC_W-1:0]            acc_w;
   logic [NP-1:0][NK-1:0]                       add_en_w;
   logic [NP-1:0][NK-1:0][ACC_W-1:0]            addend_w;
   energy_pkg::wrap_flags_t [NP-1:0]            wrap_w;
   energy_pkg::wrap_flags_t [NP-1:0]            flags_w;
   logic [NP-1:0]                               clr_w;
   logic [NWORDS-1:0][ACC_W-1:0]                rd_term_w;

   assign power_nxt = dsp_cycle_strobe ? power_in : power_r;

   for (genvar p = 0; p < NP; p++) begin : g_phase
      logic [P_W-1:0] real_w;
      logic [P_W-1:0] quad_w;
      logic           real_neg_w;
      logic           quad_neg_w;

      assign real_w     = power_r[p].real_power_value;
      assign quad_w     = power_r[p].quadrature_power_value;
      assign real_neg_w = real_w[P_W-1];
      assign quad_neg_w = quad_w[P_W-1];

      // Zero goes to the positive lane, where it changes nothing.
      assign add_en_w[p][energy_pkg::KIND_REAL_POS] = add_r & ~real_neg_w; // R1
      assign addend_w[p][energy_pkg::KIND_REAL_POS] = ACC_W'(real_w); // R1
      assign add_en_w[p][energy_pkg::KIND_REAL_NEG] = add_r & real_neg_w; // R2
      assign addend_w[p][energy_pkg::KIND_REAL_NEG] = ACC_W'(magnitude(real_w)); // R2
      assign add_en_w[p][energy_pkg::KIND_QUAD_POS] = add_r & ~quad_neg_w; // R3
      assign addend_w[p][energy_pkg::KIND_QUAD_POS] = ACC_W'(quad_w); // R3
      assign add_en_w[p][energy_pkg::KIND_QUAD_NEG] = add_r & quad_neg_w; // R4
      assign addend_w[p][energy_pkg::KIND_QUAD_NEG] = ACC_W'(magnitude(quad_w)); // R4
      // The volt-amp product is unsigned and always added.
      assign add_en_w[p][energy_pkg::KIND_VA] = add_r; // R5
      assign addend_w[p][energy_pkg::KIND_VA] = ACC_W'(power_r[p].volt_amp_product); // R5

      for (genvar k = 0; k < NK; k++) begin : g_kind
         energy_lane #(
            .ACC_W  (ACC_W)
         ) u_lane (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .add_en  (add_en_w[p][k]),
            .addend  (addend_w[p][k]),
            .acc     (acc_w[p][k]),
            .wrap    (wrap_w[p][k])
         );

         // Every accumulator of the phase, apparent energy included, has its own address.
         assign rd_term_w[p*NK+k] =
            addr_hit(reg_req.addr, energy_pkg::ENERGY_OFS[p][k]) ? acc_w[p][k]
                                                                 : energy_pkg::READ_ZERO; // R11
      end

      // Flag bit k is set by a wrap of lane k.
      assign clr_w[p] = reg_req.wr & addr_hit(reg_req.addr, energy_pkg::WRAP_OFS[p]); // R12

      wrap_status u_status (
         .clk_sys  (clk_sys),
         .rst_n    (rst_n),
         .set_vec  (wrap_w[p]), // R6 R7 R8 R9 R10
         .clr_en   (clr_w[p]),
         .clr_mask (reg_req.wdata[NK-1:0]),
         .flags    (flags_w[p])
      );

      // Reserved flag bits read as zero.
      assign rd_term_w[NP*NK+p] =
         addr_hit(reg_req.addr, energy_pkg::WRAP_OFS[p]) ? ACC_W'(flags_w[p])
                                                         : energy_pkg::READ_ZERO;
   end

   // Unmapped addresses fall through every term and read as zero.
   assign rdata_nxt = reg_req.rd ? merge_words(rd_term_w) : rdata_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         add_r   <= 1'b0;
         power_r <= '0;
      end else begin
         add_r   <= dsp_cycle_strobe;
         power_r <= power_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r  <= energy_pkg::READ_ZERO;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= reg_req.rd;
      end
   end

   assign reg_rdata          = rdata_r;
   assign reg_rvalid         = rvalid_r;
   assign energy_wrap_status = flags_w;

endmodule : phase_energy_accumulators

// File: verif/phase_energy_accumulators_monitor.sv
// Checker of the read port and sticky wrap flags of the energy accumulators.
`timescale 1ns/1ns
module phase_energy_accumulators_monitor (
   input wire logic                                            clk_sys,
   input wire logic                                            rst_n,
   input wire logic                                            dsp_cycle_strobe,
   input wire energy_pkg::phase_power_t [energy_pkg::PHASES-1:0] power_in,
   input wire energy_pkg::reg_req_t                            reg_req,
   input wire logic [energy_pkg::ACC_W-1:0]                    reg_rdata,
   input wire logic                                            reg_rvalid,
   input wire energy_pkg::wrap_flags_t [energy_pkg::PHASES-1:0] energy_wrap_status
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_RD_ANSWER: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read not answered");
   AST_RD_ONLY: assert property (!reg_req.rd |=> !reg_rvalid)
      else $error("answer without read");
   AST_RDATA_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   AST_UNMAPPED: assert property (
      reg_req.rd && reg_req.addr == 12'h000 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_FLAG_READ: assert property (
      reg_req.rd && reg_req.addr == energy_pkg::WRAP_OFS[2]
      |=> reg_rdata == {27'h0, $past(energy_wrap_status[2])})
      else $error("flag read wrong");
   // A wrap shows on its flag two edges after the strobe, since the powers are captured first.
   AST_NO_SET: assert property (
      !$past(dsp_cycle_strobe)
      |=> (energy_wrap_status & ~$past(energy_wrap_status)) == '0)
      else $error("flag set without accumulation");
   AST_STICKY: assert property (
      !reg_req.wr
      |=> (energy_wrap_status & $past(energy_wrap_status)) == $past(energy_wrap_status))
      else $error("flag dropped without write");
   AST_CLEAR_C: assert property (
      reg_req.wr && reg_req.addr == energy_pkg::WRAP_OFS[2] && !$past(dsp_cycle_strobe)
      |=> (energy_wrap_status[2] & $past(reg_req.wdata[4:0])) == 5'h00)
      else $error("flag not cleared");
endmodule : phase_energy_accumulators_monitor
bind phase_energy_accumulators phase_energy_accumulators_monitor u_mon (.clk_sys, .rst_n,
   .dsp_cycle_strobe, .power_in, .reg_req, .reg_rdata, .reg_rvalid, .energy_wrap_status);

// File: verif/energy_host.sv
// Host master model: register reads, flag clears and wrap-corrected energy differences.
`timescale 1ns/1ns
module energy_host (
   input  wire logic                         clk_sys,
   input  wire logic [energy_pkg::ACC_W-1:0] reg_rdata,
   input  wire logic                         reg_rvalid,
   output energy_pkg::reg_req_t              reg_req
);
   initial reg_req = '0;
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_req.rd   <= 1'b1;
      reg_req.addr <= a;
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      @(negedge clk_sys);
      d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXX_XXXX;
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [7:0] w);
      @(posedge clk_sys);
      reg_req.wr    <= 1'b1;
      reg_req.addr  <= a;
      reg_req.wdata <= w;
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask : wr
   // A seen wrap flag means the later reading lies one full turn ahead.
   function automatic logic [32:0] used(input logic [31:0] a, b, input logic f);
      return {1'b0, b} - {1'b0, a} + (f ? 33'h1_0000_0000 : 33'h0);
   endfunction : used
endmodule : energy_host

// File: verif/phase_energy_accumulators_bench.sv
// Self-checking bench of the phase energy accumulators.
`timescale 1ns/1ns
module phase_energy_accumulators_bench;
   logic                                             clk_sys, rst_n, dsp_cycle_strobe;
   energy_pkg::phase_power_t [energy_pkg::PHASES-1:0] power_in;
   energy_pkg::reg_req_t                             reg_req;
   logic [31:0]                                      reg_rdata, d, a0;
   logic                                             reg_rvalid;
   energy_pkg::wrap_flags_t [energy_pkg::PHASES-1:0]  energy_wrap_status;
   logic [31:0]                                      ea [3][5];
   energy_pkg::wrap_flags_t                          ef [3];
   int                                               errors, n_tests, cyc;
   phase_energy_accumulators u_dut (.clk_sys, .rst_n, .dsp_cycle_strobe, .power_in,
      .reg_req, .reg_rdata, .reg_rvalid, .energy_wrap_status);
   energy_host u_host (.clk_sys, .reg_rdata, .reg_rvalid, .reg_req);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic end_sim;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [32:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         end_sim();
      end
   end
   // Strobe stays high across calls, so successive pushes are back to back.
   task automatic push(input int p, input logic [31:0] r, q, s);
      logic [31:0] v [5];
      logic [32:0] sum;
      energy_pkg::phase_power_t [2:0] pw;
      v[0] = r[31] ? 32'h0 : r;
      v[1] = r[31] ? -r : 32'h0;
      v[2] = q[31] ? 32'h0 : q;
      v[3] = q[31] ? -q : 32'h0;
      v[4] = s;
      for (int k = 0; k < 5; k++) begin
         sum = {1'b0, ea[p][k]} + {1'b0, v[k]};
         ea[p][k] = sum[31:0];
         ef[p][k] = ef[p][k] | sum[32];
      end
      pw = '0;
      pw[p] = {r, q, s};
      @(posedge clk_sys);
      dsp_cycle_strobe <= 1'b1;
      power_in         <= pw;
   endtask : push
   task automatic stop;
      @(posedge clk_sys);
      dsp_cycle_strobe <= 1'b0;
   endtask : stop
   task automatic chk_all;
      stop();
      for (int p = 0; p < 3; p++) begin
         for (int k = 0; k < 5; k++) begin
            u_host.rd(energy_pkg::ENERGY_OFS[p][k], d);
            chk(d, ea[p][k]);
         end
         u_host.rd(energy_pkg::WRAP_OFS[p], d);
         chk(d, {27'h0, ef[p]});
         chk(energy_wrap_status[p], ef[p]);
      end
   endtask : chk_all
   task automatic t_signs;
      for (int p = 0; p < 3; p++) begin
         // Every lane gets a value of its own per phase, so a crossed address shows.
         push(p, 32'h0000_1234 + p, 32'hFFFF_FF00 - p, 32'h0000_5000 + p);
         push(p, 32'hFFFF_FFF0 - p, 32'h0000_0777 + p, 32'h0);
      end
      chk_all();
   endtask : t_signs
   task automatic t_wrap;
      u_host.rd(energy_pkg::ENERGY_OFS[2][0], a0);
      repeat (3) push(2, 32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFF);
      stop();
      u_host.rd(energy_pkg::ENERGY_OFS[2][0], d);
      chk(u_host.used(a0, d, energy_wrap_status[2][0]), 33'h1_7FFF_FFFD);
      repeat (3) push(2, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0);
      chk_all();
   endtask : t_wrap
   task automatic t_clear;
      u_host.wr(energy_pkg::WRAP_OFS[2], 8'hE1);
      ef[2][0] = 1'b0;
      u_host.wr(energy_pkg::ENERGY_OFS[2][4], 8'hFF);
      u_host.rd(12'h000, d);
      chk(d, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk_all();
   endtask : t_clear
   task automatic t_ab;
      for (int p = 0; p < 2; p++) begin
         repeat (3) push(p, 32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFF);
         stop();
         u_host.wr(energy_pkg::WRAP_OFS[p], 8'h0A);
         ef[p] = ef[p] & 5'h15;
      end
      chk_all();
   endtask : t_ab
   initial begin
      rst_n = 1'b0;
      dsp_cycle_strobe = 1'b0;
      power_in = '0;
      errors = 0;
      n_tests = 0;
      cyc = 0;
      foreach (ea[p, k]) ea[p][k] = 32'h0;
      foreach (ef[p]) ef[p] = 5'h00;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk_all();
      t_signs();
      t_wrap();
      t_clear();
      t_ab();
      end_sim();
   end
endmodule : phase_energy_accumulators_bench
